// file: fpme_top.sv
// Flash programming mode entry, communication mode select and sync logic.
`default_nettype none

module fpme_top (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Programmer pins
	input wire logic modeSelectPin,
	input wire logic serialReceivePin,
	output logic serialTransmitPin,
	// Mode status
	output logic programMode_r,
	output logic normalMode_r,
	output logic holdPinsAtReset_r,
	output logic commModeValid_r,
	output logic useExternalClock_r,
	output logic modeFault_r,
	output logic linkSynced_r,
	// Received commands
	output logic [7:0] commandByte_r,
	output logic commandStrobe_r
);

	// ========================================
	// Declarations
	fpme_pkg::fpme_state_t state_r;
	fpme_tx_if txBus ();
	logic modePrev_r;
	logic rxPrev_r;
	logic [2:0] pulseCount_r;
	logic [3:0] subCount_r;
	logic [15:0] bitPeriod_r;
	logic [15:0] timer_r;
	logic [3:0] bitIndex_r;
	logic [7:0] rxShift_r;
	logic txStart_r;
	logic [7:0] txData_r;
	logic rxFall;
	logic rxByteDone;
	logic cmdKnown;

	assign rxFall = rxPrev_r && !serialReceivePin;
	assign rxByteDone = (state_r == fpme_pkg::FPME_ST_RX_BITS) &&
		(timer_r == 16'h0000) && (bitIndex_r == fpme_pkg::FPME_DATA_BITS + 4'h1);
	assign txBus.start = txStart_r;
	assign txBus.data = txData_r;
	assign txBus.bitPeriod = bitPeriod_r;

	always_comb
	begin
		cmdKnown = 1'b0;
		for (int i = 0; i < fpme_pkg::FPME_NUM_CMDS; i++)
		begin
			if (rxShift_r == fpme_pkg::FPME_CMD_CODES[i])
			begin
				cmdKnown = 1'b1;
			end
		end
	end

	// ========================================
	// Edge history of the two input pins
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			modePrev_r <= 1'b0;
			rxPrev_r <= 1'b1;
		end
		else
		begin
			modePrev_r <= modeSelectPin;
			rxPrev_r <= serialReceivePin;
		end
	end

	// ========================================
	// Operating mode chosen at reset release
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			programMode_r <= 1'b0;
			normalMode_r <= 1'b0;
			holdPinsAtReset_r <= 1'b0;
		end
		else if (state_r == fpme_pkg::FPME_ST_SAMPLE)
		begin
			programMode_r <= modeSelectPin;
			normalMode_r <= !modeSelectPin;
			holdPinsAtReset_r <= modeSelectPin;
		end
	end

	// ========================================
	// Pulse counting and communication mode latch
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			pulseCount_r <= fpme_pkg::FPME_PULSES_CRYSTAL;
			commModeValid_r <= 1'b0;
			useExternalClock_r <= 1'b0;
			modeFault_r <= 1'b0;
		end
		else if (state_r == fpme_pkg::FPME_ST_COUNT)
		begin
			if (rxFall)
			begin
				commModeValid_r <= 1'b1;
				useExternalClock_r <=
					(pulseCount_r == fpme_pkg::FPME_PULSES_EXTCLK);
				modeFault_r <=
					(pulseCount_r != fpme_pkg::FPME_PULSES_CRYSTAL) &&
					(pulseCount_r != fpme_pkg::FPME_PULSES_EXTCLK);
			end
			else if (modeSelectPin && !modePrev_r &&
				pulseCount_r != fpme_pkg::FPME_PULSES_MAX)
			begin
				pulseCount_r <= pulseCount_r + 3'h1;
			end
		end
	end

	// ========================================
	// Main sequencer: bit period measurement, reception and answers
	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			state_r <= fpme_pkg::FPME_ST_SAMPLE;
			subCount_r <= 4'h0;
			bitPeriod_r <= fpme_pkg::FPME_BIT_CYCLES_NOM;
			timer_r <= 16'h0000;
			bitIndex_r <= 4'h0;
			rxShift_r <= 8'h00;
			txStart_r <= 1'b0;
			txData_r <= fpme_pkg::FPME_RESP_NAK;
			linkSynced_r <= 1'b0;
			commandByte_r <= 8'h00;
			commandStrobe_r <= 1'b0;
		end
		else
		begin
			txStart_r <= 1'b0;
			commandStrobe_r <= 1'b0;
			case (state_r)
				fpme_pkg::FPME_ST_SAMPLE:
				begin
					if (modeSelectPin)
					begin
						state_r <= fpme_pkg::FPME_ST_COUNT;
					end
					else
					begin
						state_r <= fpme_pkg::FPME_ST_NORMAL;
					end
				end
				fpme_pkg::FPME_ST_NORMAL:
				begin
					state_r <= fpme_pkg::FPME_ST_NORMAL;
				end
				fpme_pkg::FPME_ST_COUNT:
				begin
					if (rxFall)
					begin
						if ((pulseCount_r == fpme_pkg::FPME_PULSES_CRYSTAL) ||
							(pulseCount_r == fpme_pkg::FPME_PULSES_EXTCLK))
						begin
							state_r <= fpme_pkg::FPME_ST_MEASURE;
							subCount_r <= 4'h1;
							bitPeriod_r <= 16'h0000;
						end
						else
						begin
							state_r <= fpme_pkg::FPME_ST_FAULT;
						end
					end
				end
				fpme_pkg::FPME_ST_MEASURE:
				begin
					// The reset command is all zeros: start bit and eight data
					// bits form one low run, so its length over nine is a bit.
					if (serialReceivePin)
					begin
						if (bitPeriod_r < fpme_pkg::FPME_BIT_CYCLES_MIN)
						begin
							state_r <= fpme_pkg::FPME_ST_FAULT;
						end
						else
						begin
							linkSynced_r <= 1'b1;
							txData_r <= fpme_pkg::FPME_RESP_ACK;
							txStart_r <= 1'b1;
							state_r <= fpme_pkg::FPME_ST_RESPOND;
						end
					end
					else if (subCount_r == fpme_pkg::FPME_SYNC_BITS_M1)
					begin
						subCount_r <= 4'h0;
						if (bitPeriod_r != 16'hFFFF)
						begin
							bitPeriod_r <= bitPeriod_r + 16'h0001;
						end
					end
					else
					begin
						subCount_r <= subCount_r + 4'h1;
					end
				end
				fpme_pkg::FPME_ST_RESPOND:
				begin
					if (!txStart_r && !txBus.busy)
					begin
						state_r <= fpme_pkg::FPME_ST_RX_IDLE;
					end
				end
				fpme_pkg::FPME_ST_RX_IDLE:
				begin
					if (rxFall)
					begin
						timer_r <= {1'b0, bitPeriod_r[15:1]};
						bitIndex_r <= 4'h0;
						state_r <= fpme_pkg::FPME_ST_RX_BITS;
					end
				end
				fpme_pkg::FPME_ST_RX_BITS:
				begin
					if (timer_r != 16'h0000)
					begin
						timer_r <= timer_r - 16'h0001;
					end
					else if (bitIndex_r == 4'h0 && serialReceivePin)
					begin
						state_r <= fpme_pkg::FPME_ST_RX_IDLE;
					end
					else if (rxByteDone)
					begin
						if (serialReceivePin && cmdKnown)
						begin
							txData_r <= fpme_pkg::FPME_RESP_ACK;
							commandByte_r <= rxShift_r;
							commandStrobe_r <= 1'b1;
						end
						else
						begin
							txData_r <= fpme_pkg::FPME_RESP_NAK;
						end
						txStart_r <= 1'b1;
						state_r <= fpme_pkg::FPME_ST_RESPOND;
					end
					else
					begin
						if (bitIndex_r != 4'h0)
						begin
							rxShift_r <= {serialReceivePin, rxShift_r[7:1]};
						end
						bitIndex_r <= bitIndex_r + 4'h1;
						timer_r <= bitPeriod_r - 16'h0001;
					end
				end
				fpme_pkg::FPME_ST_FAULT:
				begin
					state_r <= fpme_pkg::FPME_ST_FAULT;
				end
				default:
				begin
					state_r <= fpme_pkg::FPME_ST_SAMPLE;
				end
			endcase
		end
	end

	// ========================================
	// Response transmitter
	fpme_uart_tx txUnit (
		.ref_clk(ref_clk),
		.reset(reset),
		.txPort(txBus.tx),
		.serialTransmitPin(serialTransmitPin)
	);

endmodule

`default_nettype wire

// file: fpme_pkg.sv
// Package of constants and types for the flash programming mode entry block.
`default_nettype none

package fpme_pkg;

	// ========================================
	// Timing
	localparam int unsigned FPME_CLK_HZ = 40000000;
	localparam int unsigned FPME_BAUD_BPS = 115200;
	localparam logic [15:0] FPME_BIT_CYCLES_NOM =
		16'(FPME_CLK_HZ / FPME_BAUD_BPS);
	localparam logic [15:0] FPME_BIT_CYCLES_MIN = 16'h0004;
	localparam logic [3:0] FPME_SYNC_BITS_M1 = 4'h8;

	// ========================================
	// Mode-select pulse counts
	localparam logic [2:0] FPME_PULSES_CRYSTAL = 3'h0;
	localparam logic [2:0] FPME_PULSES_EXTCLK = 3'h3;
	localparam logic [2:0] FPME_PULSES_MAX = 3'h7;

	// ========================================
	// Frames
	localparam logic [3:0] FPME_DATA_BITS = 4'h8;
	localparam logic [7:0] FPME_RESP_ACK = 8'h06;
	localparam logic [7:0] FPME_RESP_NAK = 8'h15;
	localparam logic [7:0] FPME_CMD_RESET = 8'h00;
	localparam int FPME_NUM_CMDS = 12;
	localparam logic [7:0] FPME_CMD_CODES [FPME_NUM_CMDS] = '{
		8'h00, 8'h13, 8'h20, 8'h22, 8'h32, 8'h40,
		8'h70, 8'h90, 8'hA0, 8'hB0, 8'hC0, 8'hC5
	};

	// ========================================
	// Main sequencer states
	typedef enum logic [3:0] {
		FPME_ST_SAMPLE = 4'h0,
		FPME_ST_NORMAL = 4'h1,
		FPME_ST_COUNT = 4'h2,
		FPME_ST_MEASURE = 4'h3,
		FPME_ST_RX_IDLE = 4'h4,
		FPME_ST_RX_BITS = 4'h5,
		FPME_ST_RESPOND = 4'h6,
		FPME_ST_FAULT = 4'h7
	} fpme_state_t;

endpackage

`default_nettype wire

// file: fpme_tx_if.sv
// Interface between the entry sequencer and its response transmitter.
`default_nettype none

interface fpme_tx_if;
	logic start;
	logic [7:0] data;
	logic [15:0] bitPeriod;
	logic busy;

	modport seq (output start, output data, output bitPeriod, input busy);
	modport tx (input start, input data, input bitPeriod, output busy);
endinterface

`default_nettype wire

// file: fpme_uart_tx.sv
// Response transmitter: one start bit, eight data bits LSB first, one stop.
`default_nettype none

module fpme_uart_tx (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Sequencer side
	fpme_tx_if.tx txPort,
	// Pin
	output logic serialTransmitPin
);

	// ========================================
	// Shift register and bit timer
	logic [9:0] shift_r;
	logic [3:0] bitsLeft_r;
	logic [15:0] timer_r;

	assign txPort.busy = (bitsLeft_r != 4'h0);

	always_ff @(posedge ref_clk)
	begin
		if (reset)
		begin
			shift_r <= 10'h3FF;
			bitsLeft_r <= 4'h0;
			timer_r <= 16'h0000;
			serialTransmitPin <= 1'b1;
		end
		else if (bitsLeft_r == 4'h0)
		begin
			serialTransmitPin <= 1'b1;
			if (txPort.start)
			begin
				shift_r <= {1'b1, txPort.data, 1'b0};
				bitsLeft_r <= 4'hA;
				timer_r <= 16'h0000;
			end
		end
		else if (timer_r == 16'h0000)
		begin
			serialTransmitPin <= shift_r[0];
			shift_r <= {1'b1, shift_r[9:1]};
			timer_r <= txPort.bitPeriod - 16'h0001;
		end
		else
		begin
			timer_r <= timer_r - 16'h0001;
			if (timer_r == 16'h0001)
			begin
				bitsLeft_r <= bitsLeft_r - 4'h1;
			end
		end
	end

endmodule

`default_nettype wire

// file: fpme_top_asserts.sv
// Port assertions for the programming mode entry block.
`default_nettype none

module fpme_top_asserts (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Pins
	input wire logic modeSelectPin,
	input wire logic serialReceivePin,
	input wire logic serialTransmitPin,
	// Status
	input wire logic programMode_r,
	input wire logic normalMode_r,
	input wire logic holdPinsAtReset_r,
	input wire logic commModeValid_r,
	input wire logic useExternalClock_r,
	input wire logic modeFault_r,
	input wire logic linkSynced_r,
	// Commands
	input wire logic [7:0] commandByte_r,
	input wire logic commandStrobe_r
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);

	// ========================================
	// Checks
	a_mode_entry: assert property ($past(reset) && !reset |=>
		programMode_r == $past(modeSelectPin) &&
		normalMode_r == !$past(modeSelectPin)) else $error("mode entry");
	a_mode_stays: assert property (programMode_r |=> programMode_r)
		else $error("mode lost");
	a_hold_pins: assert property (holdPinsAtReset_r == programMode_r)
		else $error("pin hold");
	a_normal_silent: assert property (normalMode_r |->
		serialTransmitPin && !commModeValid_r) else $error("normal talks");
	a_valid_prog: assert property (commModeValid_r |-> programMode_r)
		else $error("mode without entry");
	a_mode_latched: assert property (commModeValid_r |=>
		$stable(useExternalClock_r) && commModeValid_r) else $error("relatch");
	a_clock_choice: assert property (useExternalClock_r |-> !modeFault_r)
		else $error("clock and fault");
	a_fault_silent: assert property (modeFault_r |->
		serialTransmitPin && !linkSynced_r) else $error("fault talks");
	a_sync_first: assert property (commandStrobe_r |-> linkSynced_r)
		else $error("command before sync");
	a_strobe_answer: assert property (commandStrobe_r |=>
		!commandStrobe_r ##[0:2] !serialTransmitPin) else $error("no answer");
	a_sync_ack: assert property ($rose(linkSynced_r) |->
		##[0:3] !serialTransmitPin) else $error("no sync answer");

	c_command: cover property (commandStrobe_r);
	c_ext_sync: cover property ($rose(linkSynced_r) && useExternalClock_r);
	c_fault: cover property ($rose(modeFault_r));
endmodule

`default_nettype wire

// file: fpme_prog_model.sv
// Model of the external programmer: mode pin and UART line.
`default_nettype none

module fpme_prog_model (
	// Clock
	input wire logic ref_clk,
	// Programmer pins
	output var logic modeSelectPin,
	output var logic serialReceivePin,
	input wire logic serialTransmitPin
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		modeSelectPin = 1'b0;
		serialReceivePin = 1'b1;
	end

	// ========================================
	// Pin tasks
	task automatic setPin(input logic lvl);
		modeSelectPin = lvl;
	endtask

	task automatic pulses(input int n);
		repeat (n)
		begin
			@(negedge ref_clk);
			modeSelectPin = 1'b0;
			repeat (4) @(negedge ref_clk);
			modeSelectPin = 1'b1;
			repeat (3) @(negedge ref_clk);
		end
	endtask

	task automatic sendByte(input logic [7:0] b, input int per);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(negedge ref_clk);
			serialReceivePin = f[i];
			repeat (per - 1) @(negedge ref_clk);
		end
	endtask

	task automatic getByte(input int per, output logic [7:0] b);
		int n;
		n = 0;
		b = 8'hXX;
		while (serialTransmitPin && n < 40 * per)
		begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 40 * per)
			return;
		repeat (per / 2) @(negedge ref_clk);
		for (int i = 0; i < 8; i++)
		begin
			repeat (per) @(negedge ref_clk);
			b[i] = serialTransmitPin;
		end
		repeat (per) @(negedge ref_clk);
		if (serialTransmitPin !== 1'b1)
			b = 8'hXX;
		// Let the stop bit end and the block return to idle before the
		// caller starts the next frame, or that frame would be ignored.
		repeat (per / 2 + 2) @(negedge ref_clk);
	endtask
endmodule

`default_nettype wire

// file: tb_top.sv
// Top testbench for the programming mode entry block.
`default_nettype none

module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 8;
	logic ref_clk, reset, modeSelectPin, serialReceivePin;
	logic serialTransmitPin, programMode_r, normalMode_r, holdPinsAtReset_r;
	logic commModeValid_r, useExternalClock_r, modeFault_r, linkSynced_r;
	logic [7:0] commandByte_r;
	logic commandStrobe_r;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int nStrobe = 0;

	fpme_top fpme_top_i (.ref_clk(ref_clk), .reset(reset),
		.modeSelectPin(modeSelectPin), .serialReceivePin(serialReceivePin),
		.serialTransmitPin(serialTransmitPin), .programMode_r(programMode_r),
		.normalMode_r(normalMode_r), .holdPinsAtReset_r(holdPinsAtReset_r),
		.commModeValid_r(commModeValid_r),
		.useExternalClock_r(useExternalClock_r), .modeFault_r(modeFault_r),
		.linkSynced_r(linkSynced_r), .commandByte_r(commandByte_r),
		.commandStrobe_r(commandStrobe_r));
	fpme_prog_model fpme_prog_model_i (.ref_clk(ref_clk),
		.modeSelectPin(modeSelectPin), .serialReceivePin(serialReceivePin),
		.serialTransmitPin(serialTransmitPin));

	initial
	begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end

	// ========================================
	// Helpers
	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic startUp(input logic lvl);
		@(negedge ref_clk);
		reset = 1'b1;
		fpme_prog_model_i.setPin(lvl);
		repeat (5) @(negedge ref_clk);
		reset = 1'b0;
		repeat (3) @(negedge ref_clk);
	endtask

	task automatic frame(input logic [7:0] cmd, input logic [7:0] exp);
		logic [7:0] resp;
		fork
			fpme_prog_model_i.sendByte(cmd, PER);
			fpme_prog_model_i.getByte(PER, resp);
		join
		chk("response", exp, resp);
	endtask

	// ========================================
	// Scenarios
	task automatic test_normal();
		startUp(1'b0);
		chk("normal", 8'h01, normalMode_r);
		chk("program", 8'h00, programMode_r);
		fpme_prog_model_i.sendByte(8'h00, PER);
		chk("valid", 8'h00, commModeValid_r);
		chk("tx", 8'h01, serialTransmitPin);
		$display("test normal done");
	endtask

	task automatic test_external();
		int s0;
		startUp(1'b1);
		chk("program", 8'h01, programMode_r);
		chk("hold", 8'h01, holdPinsAtReset_r);
		fpme_prog_model_i.pulses(3);
		frame(fpme_pkg::FPME_CMD_RESET, fpme_pkg::FPME_RESP_ACK);
		chk("synced", 8'h01, linkSynced_r);
		chk("external", 8'h01, useExternalClock_r);
		fpme_prog_model_i.pulses(2);
		chk("late pulses", 8'h01, useExternalClock_r);
		s0 = nStrobe;
		for (int i = 0; i < fpme_pkg::FPME_NUM_CMDS; i++)
			frame(fpme_pkg::FPME_CMD_CODES[i], fpme_pkg::FPME_RESP_ACK);
		chk("command", 8'hC5, commandByte_r);
		chk("strobes", 8'(fpme_pkg::FPME_NUM_CMDS),
			8'(nStrobe - s0));
		frame(8'h55, fpme_pkg::FPME_RESP_NAK);
		chk("nak strobes", 8'(fpme_pkg::FPME_NUM_CMDS),
			8'(nStrobe - s0));
		chk("nak command", 8'hC5, commandByte_r);
		$display("test external done");
	endtask

	task automatic test_crystal();
		startUp(1'b1);
		frame(fpme_pkg::FPME_CMD_RESET, fpme_pkg::FPME_RESP_ACK);
		chk("external", 8'h00, useExternalClock_r);
		chk("fault", 8'h00, modeFault_r);
		$display("test crystal done");
	endtask

	task automatic test_fault();
		startUp(1'b1);
		fpme_prog_model_i.pulses(2);
		fpme_prog_model_i.sendByte(8'h00, PER);
		chk("fault", 8'h01, modeFault_r);
		chk("synced", 8'h00, linkSynced_r);
		chk("tx", 8'h01, serialTransmitPin);
		$display("test fault done");
	endtask

	task automatic test_short();
		startUp(1'b1);
		fpme_prog_model_i.sendByte(8'h00, 2);
		chk("short sync", 8'h00, linkSynced_r);
		fpme_prog_model_i.sendByte(8'h00, PER);
		chk("short tx", 8'h01, serialTransmitPin);
		chk("short dead", 8'h00, linkSynced_r);
		$display("test short done");
	endtask

	always @(negedge ref_clk)
	begin
		if (commandStrobe_r === 1'b1)
			nStrobe++;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			n_mismatch++;
			end_sim();
		end
	end

	initial
	begin
		reset = 1'b1;
		test_normal();
		test_external();
		test_crystal();
		test_fault();
		test_short();
		end_sim();
	end
endmodule

bind fpme_top fpme_top_asserts fpme_top_asserts_i (.ref_clk(ref_clk),
	.reset(reset), .modeSelectPin(modeSelectPin),
	.serialReceivePin(serialReceivePin), .serialTransmitPin(serialTransmitPin),
	.programMode_r(programMode_r), .normalMode_r(normalMode_r),
	.holdPinsAtReset_r(holdPinsAtReset_r), .commModeValid_r(commModeValid_r),
	.useExternalClock_r(useExternalClock_r), .modeFault_r(modeFault_r),
	.linkSynced_r(linkSynced_r), .commandByte_r(commandByte_r),
	.commandStrobe_r(commandStrobe_r));

`default_nettype wire
